// ---- include/dam_defs.vh ----
// constants for the dual converter output mode control
`ifndef DAM_DEFS_VH
`define DAM_DEFS_VH

`define DAM_DATA_W          8
`define DAM_PIPE_STAGES     4
`define DAM_RECOVERY_CYCLES 15
`define DAM_RECOVERY_W      5

`define DAM_MODE_STBY_BOTH  2'h0
`define DAM_MODE_STBY_B     2'h1
`define DAM_MODE_NORMAL     2'h2
`define DAM_MODE_ALIGN      2'h3
`define DAM_MODE_RESET      2'h0

`define DAM_FMT_MSB         7

`endif

// ---- logic/dam_pipe.v ----
// sample pipeline stages advanced by one channel's encode edge
`timescale 1ns/1ps
module dam_pipe #(
  parameter W     = 8,
  parameter DEPTH = 3
) (
  input  wire         clk,
  input  wire         reset_n,
  input  wire         advance,
  input  wire [W-1:0] din,
  output wire [W-1:0] dout
);

  reg [W-1:0] stage [0:DEPTH-1];
  integer     i;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        stage[i] <= {W{1'b0}};
      end
    end else if (advance) begin
      stage[0] <= din;
      for (i = 1; i < DEPTH; i = i + 1) begin
        stage[i] <= stage[i-1];
      end
    end
  end

  // last stage feeds the output register, which is the final pipeline stage
  assign dout = stage[DEPTH-1];

endmodule // dam_pipe

// ---- logic/dam_output_control.v ----
// output mode, format and standby control of a dual 8-bit sampling converter
//
// What this block does
// (R1) straps 00: both channels in standby, no conversion output on either.
// (R2) straps 01: only channel B in standby, channel A converts normally.
// (R3) straps 10: both channels run, channel B gets no extra delay.
// (R4) straps 11: channel B output delayed half a clock cycle (data align).
// (R5) format input low gives offset binary, high gives twos complement.
// (R6) channel A advances on clock A, channel B on clock B.
// (R7) each channel drives its own 8-bit output bus, bit 7 is msb.
// (R8) sample reaches the output bus after four stages of its channel clock.
// (R9) channel leaving standby needs 15 clock cycles before data counts as valid.
// (R10) output drivers released to high impedance while channel in standby.
// (R11) shared clock, no data align: both outputs update on same rising edge.
// (R12) straps held static during conversion by the system; no change handshake.
`timescale 1ns/1ps
`include "dam_defs.vh"
module dam_output_control #(
  parameter DATA_W          = `DAM_DATA_W,
  parameter PIPE_STAGES     = `DAM_PIPE_STAGES,
  parameter RECOVERY_CYCLES = `DAM_RECOVERY_CYCLES,
  parameter RECOVERY_W      = `DAM_RECOVERY_W
) (
  input  wire              clk,
  input  wire              reset_n,
  input  wire              clk_en,
  input  wire              mode_strap_one,
  input  wire              mode_strap_two,
  input  wire              output_format_select,
  input  wire              channel_a_sample_clock,
  input  wire              channel_b_sample_clock,
  input  wire [DATA_W-1:0] channel_a_conv_word,
  input  wire [DATA_W-1:0] channel_b_conv_word,
  output reg  [DATA_W-1:0] channel_a_sample_bus,
  output reg               channel_a_bus_oe,
  output reg               channel_a_data_valid,
  output reg  [DATA_W-1:0] channel_b_sample_bus,
  output reg               channel_b_bus_oe,
  output reg               channel_b_data_valid,
  output reg  [1:0]        active_mode
);

  localparam [RECOVERY_W-1:0] REC_DONE = RECOVERY_CYCLES[RECOVERY_W-1:0];
  localparam [RECOVERY_W-1:0] REC_ONE  = {{(RECOVERY_W-1){1'b0}}, 1'b1};
  localparam [RECOVERY_W-1:0] REC_ZERO = {RECOVERY_W{1'b0}};

  // offset binary to twos complement is an msb flip
  function [DATA_W-1:0] code_word;
    input [DATA_W-1:0] raw;
    input              twos;
    begin
      code_word = raw;
      if (twos) begin
        code_word[`DAM_FMT_MSB] = ~raw[`DAM_FMT_MSB];
      end
    end
  endfunction

  // recovery count: cleared in standby, counts encode edges up to done
  function [RECOVERY_W-1:0] recover_step;
    input [RECOVERY_W-1:0] cnt;
    input                  stby;
    input                  edge_seen;
    begin
      recover_step = cnt;
      if (stby) begin
        recover_step = REC_ZERO;
      end else if (edge_seen && cnt != REC_DONE) begin
        recover_step = cnt + REC_ONE;
      end
    end
  endfunction

  reg                  sclk_a_prev;
  reg                  sclk_b_prev;
  reg [RECOVERY_W-1:0] recover_a;
  reg [RECOVERY_W-1:0] recover_b;
  reg                  stby_a;
  reg                  stby_b;
  reg                  align_b;
  reg [DATA_W-1:0]     hold_b;
  reg [RECOVERY_W-1:0] next_recover_a;
  reg [RECOVERY_W-1:0] next_recover_b;

  wire              rise_a;
  wire              rise_b;
  wire              fall_b;
  wire              advance_a;
  wire              advance_b;
  wire              load_b;
  wire [DATA_W-1:0] pipe_a_out;
  wire [DATA_W-1:0] pipe_b_out;

  // encode clocks are plain synchronous inputs; edges found against last sample
  assign rise_a = clk_en & channel_a_sample_clock & ~sclk_a_prev; // (R6)
  assign rise_b = clk_en & channel_b_sample_clock & ~sclk_b_prev; // (R6)
  assign fall_b = clk_en & ~channel_b_sample_clock & sclk_b_prev;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_a_prev <= 1'b0;
      sclk_b_prev <= 1'b0;
    end else if (clk_en) begin
      sclk_a_prev <= channel_a_sample_clock;
      sclk_b_prev <= channel_b_sample_clock;
    end
  end

  // straps are assumed static; a change simply takes effect next cycle
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      active_mode <= `DAM_MODE_RESET;
    end else if (clk_en) begin
      active_mode <= {mode_strap_one, mode_strap_two};
    end
  end

  always @* begin
    stby_a  = 1'b0;
    stby_b  = 1'b0;
    align_b = 1'b0;
    case (active_mode)
      `DAM_MODE_STBY_BOTH: begin
        stby_a = 1'b1; // (R1)
        stby_b = 1'b1; // (R1)
      end
      `DAM_MODE_STBY_B: begin
        stby_b = 1'b1; // (R2)
      end
      `DAM_MODE_NORMAL: begin
        align_b = 1'b0; // (R3)
      end
      `DAM_MODE_ALIGN: begin
        align_b = 1'b1; // (R4)
      end
      default: begin
        stby_a = 1'b1;
        stby_b = 1'b1;
      end
    endcase
  end

  // standby freezes the pipeline so nothing new is converted
  assign advance_a = rise_a & ~stby_a; // (R1) (R2)
  assign advance_b = rise_b & ~stby_b; // (R1) (R2)

  // aligned channel B loads on the falling encode edge, half a cycle late
  assign load_b = ~stby_b & (align_b ? fall_b : rise_b); // (R4) (R11)

  dam_pipe #(
    .W     (DATA_W),
    .DEPTH (PIPE_STAGES - 1)
  ) u_pipe_a (
    .clk     (clk),
    .reset_n (reset_n),
    .advance (advance_a),
    .din     (code_word(channel_a_conv_word, output_format_select)), // (R5)
    .dout    (pipe_a_out)
  );

  dam_pipe #(
    .W     (DATA_W),
    .DEPTH (PIPE_STAGES - 1)
  ) u_pipe_b (
    .clk     (clk),
    .reset_n (reset_n),
    .advance (advance_b),
    .din     (code_word(channel_b_conv_word, output_format_select)), // (R5)
    .dout    (pipe_b_out)
  );

  // aligned B must show the word normal mode loads at a rise, half a B clock later
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hold_b <= {DATA_W{1'b0}};
    end else if (advance_b) begin
      hold_b <= pipe_b_out; // (R4)
    end
  end

  // output register is the fourth stage of each channel
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      channel_a_sample_bus <= {DATA_W{1'b0}};
      channel_b_sample_bus <= {DATA_W{1'b0}};
    end else begin
      if (advance_a) begin
        channel_a_sample_bus <= pipe_a_out; // (R7) (R8) (R11)
      end
      if (load_b) begin
        channel_b_sample_bus <= align_b ? hold_b : pipe_b_out; // (R7) (R8) (R4)
      end
    end
  end

  // drivers released while in standby; bus value is held, not cleared
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      channel_a_bus_oe <= 1'b0;
      channel_b_bus_oe <= 1'b0;
    end else if (clk_en) begin
      channel_a_bus_oe <= ~stby_a; // (R10)
      channel_b_bus_oe <= ~stby_b; // (R10)
    end
  end

  always @* begin
    next_recover_a = recover_step(recover_a, stby_a, rise_a); // (R9)
    next_recover_b = recover_step(recover_b, stby_b, rise_b); // (R9)
  end

  // recovery also covers pipeline fill, since 15 exceeds the four stages
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      recover_a            <= REC_ZERO;
      recover_b            <= REC_ZERO;
      channel_a_data_valid <= 1'b0;
      channel_b_data_valid <= 1'b0;
    end else if (clk_en) begin
      recover_a            <= next_recover_a;
      recover_b            <= next_recover_b;
      channel_a_data_valid <= ~stby_a & (next_recover_a == REC_DONE); // (R9)
      channel_b_data_valid <= ~stby_b & (next_recover_b == REC_DONE); // (R9)
    end
  end

endmodule // dam_output_control

// ---- verif/dam_capture_model.sv ----
// downstream capture model latching each new word driven on one bus
`timescale 1ns/1ps
module dam_capture_model (
  input  logic       clk,
  input  logic       reset_n,
  input  logic [7:0] bus,
  input  logic       oe,
  output logic [7:0] word,
  output logic       got
);
  logic [7:0] last;
  // a released bus carries nothing, so only driven words count
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      last <= 8'h00;
      got <= 1'b0;
    end else begin
      got <= oe && (bus !== last);
      word <= bus;
      if (oe) last <= bus;
    end
  end
endmodule // dam_capture_model

// ---- verif/dam_output_control_checker.sv ----
// assertions on the output control ports
`timescale 1ns/1ps
module dam_output_control_checker (
  input logic       clk,
  input logic       reset_n,
  input logic       clk_en,
  input logic       channel_a_sample_clock,
  input logic       channel_b_sample_clock,
  input logic [7:0] channel_a_sample_bus,
  input logic [7:0] channel_b_sample_bus,
  input logic       channel_a_bus_oe,
  input logic       channel_b_bus_oe,
  input logic       channel_a_data_valid,
  input logic       channel_b_data_valid,
  input logic [1:0] active_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  stby_both_a: assert property (active_mode == 2'h0 && clk_en |=>
    !channel_a_bus_oe && !channel_b_bus_oe && !channel_a_data_valid) else $error("both standby");
  stby_b_a: assert property (active_mode == 2'h1 && clk_en |=>
    channel_a_bus_oe && !channel_b_bus_oe && !channel_b_data_valid) else $error("b standby");
  run_both_a: assert property (active_mode[1] && clk_en |=>
    channel_a_bus_oe && channel_b_bus_oe) else $error("both run");
  stby_hold_a: assert property (active_mode == 2'h0 |=>
    $stable(channel_a_sample_bus) && $stable(channel_b_sample_bus)) else $error("standby load");
  a_on_rise_a: assert property ($changed(channel_a_sample_bus) |->
    $past(channel_a_sample_clock) && !$past(channel_a_sample_clock, 2)) else $error("a load");
  b_on_rise_a: assert property ($changed(channel_b_sample_bus) && $past(active_mode) == 2'h2 |->
    $past(channel_b_sample_clock) && !$past(channel_b_sample_clock, 2)) else $error("b load");
  b_on_fall_a: assert property ($changed(channel_b_sample_bus) && $past(active_mode) == 2'h3 |->
    !$past(channel_b_sample_clock) && $past(channel_b_sample_clock, 2)) else $error("b align");
  a_valid_set_a: assert property ($rose(channel_a_data_valid) |->
    $past(channel_a_sample_clock) && !$past(channel_a_sample_clock, 2)) else $error("a valid");
endmodule // dam_output_control_checker
bind dam_output_control dam_output_control_checker dam_output_control_checker_i (.*);

// ---- verif/test_dual_adc_output_mode_control.sv ----
// self-checking bench for the dual converter output control
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end
module test_dual_adc_output_mode_control;
  logic       clk, reset_n, en, s1, s2, fmt, ca, cb, oe_a, oe_b, val_a, val_b, got_a, got_b;
  logic [7:0] wa, wb, pa, pb, ea, eb, bus_a, bus_b, word_a, word_b, lb;
  logic [1:0] mode_q;
  logic [7:0] qa[$], qb[$];
  int         n_mismatch, total_checks;
  dam_output_control dam_output_control_i (.clk(clk), .reset_n(reset_n), .clk_en(en), .mode_strap_one(s1),
    .mode_strap_two(s2), .output_format_select(fmt), .channel_a_sample_clock(ca), .channel_b_sample_clock(cb),
    .channel_a_conv_word(wa), .channel_b_conv_word(wb), .channel_a_sample_bus(bus_a), .channel_a_bus_oe(oe_a),
    .channel_a_data_valid(val_a), .channel_b_sample_bus(bus_b), .channel_b_bus_oe(oe_b),
    .channel_b_data_valid(val_b), .active_mode(mode_q));
  dam_capture_model cap_a (.clk(clk), .reset_n(reset_n), .bus(bus_a), .oe(oe_a), .word(word_a), .got(got_a));
  dam_capture_model cap_b (.clk(clk), .reset_n(reset_n), .bus(bus_b), .oe(oe_b), .word(word_b), .got(got_b));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (got_a) begin
      ea = qa.size() ? qa.pop_front() : 8'hxx;
      `CHK("bus_a", ea, word_a)
    end
    if (got_b) begin
      eb = qb.size() ? qb.pop_front() : 8'hxx;
      `CHK("bus_b", eb, word_b)
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // fr marks channels just out of standby; words step by 1..100 so neighbours never match
  task automatic run(input logic [1:0] m, input logic f, input logic [1:0] fr);
    {s1, s2} = m;
    fmt = f;
    repeat (4) @(negedge clk);
    // encode edges while disabled must leave pipes, buses and counters alone
    {en, wa, wb, ca, cb} = {1'b0, ~pa, ~pb, 2'b11};
    repeat (2) @(negedge clk);
    {ca, cb} = 2'b00;
    repeat (2) @(negedge clk);
    en = 1'b1;
    for (int i = 0; i < 20; i++) begin
      if (i == 14 && fr[1]) `CHK("val_a", 1'b0, val_a)
      if (i == 14 && fr[0]) `CHK("val_b", 1'b0, val_b)
      if (m != 2'h0) begin
        pa += 8'(1 + $urandom % 100);
        qa.push_back(f ? pa ^ 8'h80 : pa);
      end
      if (m[1]) begin
        pb += 8'(1 + $urandom % 100);
        qb.push_back(f ? pb ^ 8'h80 : pb);
      end
      lb = bus_b;
      {wa, wb, ca, cb} = {pa, pb, 2'b11};
      repeat (2) @(negedge clk);
      if (m == 2'h3) `CHK("b_half", lb, bus_b)
      {ca, cb} = 2'b00;
      repeat (2) @(negedge clk);
      if (m == 2'h3) `CHK("b_fall", 1'b1, bus_b !== lb)
    end
    repeat (4) @(negedge clk);
    `CHK("oe_a", m != 2'h0, oe_a)
    `CHK("oe_b", m[1], oe_b)
    `CHK("val_a", m != 2'h0, val_a)
    `CHK("val_b", m[1], val_b)
    if (m != 2'h0) `CHK("pend_a", 3, qa.size())
    if (m[1]) `CHK("pend_b", 3, qb.size())
    `CHK("mode", m, mode_q)
    $display("test mode %b format %b done", m, f);
  endtask
  initial begin
    {reset_n, s1, s2, fmt, ca, cb, wa, wb, pa, pb} = '0;
    void'($urandom(79));
    repeat (6) @(negedge clk);
    {reset_n, en} = 2'b11;
    run(2'h2, 1'b0, 2'h3);
    run(2'h1, 1'b1, 2'h0);
    run(2'h0, 1'b0, 2'h0);
    run(2'h2, 1'b1, 2'h3);
    run(2'h3, 1'b0, 2'h0);
    conclude();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    conclude();
  end
endmodule // test_dual_adc_output_mode_control
